// ### verilog/gpio_bank_pkg.sv
// ----------------------------------------------------------------
// shared constants of the gpio bank
// ----------------------------------------------------------------
package gpio_bank_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NUM_PORTS = 32;     // four banks of eight ports
  localparam int ADDR_W = 12;        // axi byte address width
  localparam int CFG_W = 4;          // stored configuration bits

  // ------------------------------------------------------------
  // register indices (byte address is index times four)
  // ------------------------------------------------------------
  localparam logic [7:0] DATA_BANK_ONE_IDX = 8'h4B;   // ports 0..7
  localparam logic [7:0] DATA_BANK_TWO_IDX = 8'h4C;   // ports 8..15
  localparam logic [7:0] DATA_BANK_THREE_IDX = 8'h4D; // ports 16..23
  localparam logic [7:0] DATA_BANK_FIVE_IDX = 8'h4F;  // ports 24..31
  localparam logic [2:0] CFG_BASE_TOP = 3'h3;         // 0x60..0x7F, one per port
  localparam logic [7:0] EVT_STATUS_IDX = 8'h80;      // sticky events, write one to clear
  localparam logic [7:0] EVT_MASK_IDX = 8'h81;        // interrupt mask

  // ------------------------------------------------------------
  // configuration field positions
  // ------------------------------------------------------------
  localparam int CFG_DIR_BIT = 0;      // 1 input, 0 output
  localparam int CFG_ALT_BIT = 1;      // 1 alternate function owns pin
  localparam int CFG_WAKE_EN_BIT = 2;  // event raises wake
  localparam int CFG_SMI_EN_BIT = 3;   // event raises mgmt interrupt

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [CFG_W-1:0] CFG_RESET_INPUT = 4'h1;
  localparam logic [CFG_W-1:0] CFG_RESET_OUTPUT = 4'h0;
  localparam logic [31:0] EVT_MASK_RESET = 32'h0;
  localparam int SERIAL_TX_SHARED_PORT = 27;  // bank five bit 3
  localparam int FAN_SHARED_PORT = 19;        // bank three bit 3

  // ------------------------------------------------------------
  // axi responses
  // ------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gpio_bank_pkg

// ### verilog/gpio_in_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// two-stage synchroniser with edge detect on the clean stage
// ----------------------------------------------------------------
module gpio_in_sync #(
  parameter int WIDTH = 33
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // asynchronous inputs
  input wire logic [WIDTH-1:0] async_i,
  // synchronised level and any-edge pulse
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] edge_o
);

  logic [WIDTH-1:0] meta_q;  // first stage, read only by sync_q
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;  // second stage
  logic [WIDTH-1:0] sync_d;
  logic [WIDTH-1:0] prev_q;  // history for edge detect
  logic [WIDTH-1:0] prev_d;

  // next values of the chain
  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // register the chain
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level_o = sync_q;
  assign edge_o = sync_q ^ prev_q;

endmodule : gpio_in_sync
`default_nettype wire

// ### verilog/general_purpose_io_bank.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module general_purpose_io_bank (
  // clock and standby-supply reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // main-supply power-on reset, asynchronous, active high
  input wire logic main_por_i,
  // axi4-lite write address
  input wire logic [gpio_bank_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  // axi4-lite write data
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  // axi4-lite write response
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  // axi4-lite read address
  input wire logic [gpio_bank_pkg::ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  // axi4-lite read data
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // pins
  input wire logic [gpio_bank_pkg::NUM_PORTS-1:0] gpio_in_i,
  output logic [gpio_bank_pkg::NUM_PORTS-1:0] gpio_out_o,
  output logic [gpio_bank_pkg::NUM_PORTS-1:0] gpio_oe_o,
  // alternate function drive
  input wire logic [gpio_bank_pkg::NUM_PORTS-1:0] alt_out_i,
  input wire logic [gpio_bank_pkg::NUM_PORTS-1:0] alt_oe_i,
  // event outputs
  output logic wake_event_pin_n_o,
  output logic mgmt_interrupt_pin_n_o,
  output logic irq_o
);

  localparam int NP = gpio_bank_pkg::NUM_PORTS;

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  logic [NP:0] sync_lvl;   // pins plus main reset
  logic [NP:0] sync_edge;
  logic [NP-1:0] pin_lvl;  // clean pin levels
  logic [NP-1:0] pin_edge; // one-cycle pin activity
  logic main_por;          // synchronised main reset

  // pins reach the wakeup path no matter direction or alt select
  gpio_in_sync #(.WIDTH(NP + 1)) u_in_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({main_por_i, gpio_in_i}),
    .level_o(sync_lvl),
    .edge_o(sync_edge)
  );

  assign pin_lvl = sync_lvl[NP-1:0];
  assign pin_edge = sync_edge[NP-1:0];
  assign main_por = sync_lvl[NP];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [gpio_bank_pkg::CFG_W-1:0] cfg_q [NP];  // per-port configuration
  logic [gpio_bank_pkg::CFG_W-1:0] cfg_d [NP];
  logic [NP-1:0] data_q;    // written data bits
  logic [NP-1:0] data_d;
  logic [31:0] status_q;    // sticky event flags
  logic [31:0] status_d;
  logic [31:0] mask_q;      // interrupt mask
  logic [31:0] mask_d;
  logic [NP-1:0] wake_en;   // configuration views
  logic [NP-1:0] smi_en;
  logic [NP-1:0] is_input;
  logic [NP-1:0] is_alt;

  // ----------------------------------------------------------------
  // bus handshake state
  // ----------------------------------------------------------------
  logic awready_q;
  logic awready_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic arready_q;
  logic arready_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_en;              // write handshake cycle
  logic rd_en;              // read handshake cycle

  assign wr_en = awready_q && awvalid_i && wvalid_i;
  assign rd_en = arready_q && arvalid_i;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // returns {hit, bank}; bank selects eight ports
  function automatic logic [2:0] data_bank(input logic [7:0] idx);
    logic [2:0] r;
    r = 3'h0;
    unique case (idx)
      gpio_bank_pkg::DATA_BANK_ONE_IDX: r = 3'h4;
      gpio_bank_pkg::DATA_BANK_TWO_IDX: r = 3'h5;
      gpio_bank_pkg::DATA_BANK_THREE_IDX: r = 3'h6;
      gpio_bank_pkg::DATA_BANK_FIVE_IDX: r = 3'h7;
      default: r = 3'h0;
    endcase
    return r;
  endfunction : data_bank

  // word index only when aligned and inside the block
  function automatic logic [8:0] word_idx(input logic [gpio_bank_pkg::ADDR_W-1:0] a);
    logic [8:0] r;
    r = {1'b0, a[9:2]};
    if (a[1:0] != 2'h0 || a[11:10] != 2'h0) begin
      r = 9'h100;  // marks no register
    end
    return r;
  endfunction : word_idx

  // ----------------------------------------------------------------
  // configuration views
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_view
      assign is_input[gp] = cfg_q[gp][gpio_bank_pkg::CFG_DIR_BIT];
      assign is_alt[gp] = cfg_q[gp][gpio_bank_pkg::CFG_ALT_BIT];
      assign wake_en[gp] = cfg_q[gp][gpio_bank_pkg::CFG_WAKE_EN_BIT];
      assign smi_en[gp] = cfg_q[gp][gpio_bank_pkg::CFG_SMI_EN_BIT];
    end
  endgenerate

  // ----------------------------------------------------------------
  // register file next values
  // ----------------------------------------------------------------
  always_comb begin
    logic [8:0] widx;
    logic [2:0] wbank;
    logic [31:0] lane;
    widx = word_idx(awaddr_i);
    wbank = data_bank(widx[7:0]);
    lane = {{8{wstrb_i[3]}}, {8{wstrb_i[2]}}, {8{wstrb_i[1]}}, {8{wstrb_i[0]}}};
    cfg_d = cfg_q;
    data_d = data_q;
    mask_d = mask_q;
    bresp_d = bresp_q;
    if (wr_en) begin
      bresp_d = gpio_bank_pkg::RESP_OKAY;
      if (widx[8]) begin
        // misaligned or outside the block
        bresp_d = gpio_bank_pkg::RESP_SLVERR;
      end else if (wbank[2]) begin
        // data bank: eight port bits in low byte
        if (wstrb_i[0]) begin
          data_d[wbank[1:0]*8 +: 8] = wdata_i[7:0];
        end
      end else if (widx[7:5] == gpio_bank_pkg::CFG_BASE_TOP) begin
        // one configuration register per port
        if (wstrb_i[0]) begin
          cfg_d[widx[4:0]] = wdata_i[gpio_bank_pkg::CFG_W-1:0];
        end
      end else if (widx[7:0] == gpio_bank_pkg::EVT_MASK_IDX) begin
        mask_d = (mask_q & ~lane) | (wdata_i & lane);
      end else if (widx[7:0] != gpio_bank_pkg::EVT_STATUS_IDX) begin
        bresp_d = gpio_bank_pkg::RESP_SLVERR;
      end
    end
    // main-supply reset forces the fan and serial tx ports out low
    if (main_por) begin
      cfg_d[gpio_bank_pkg::FAN_SHARED_PORT] = gpio_bank_pkg::CFG_RESET_OUTPUT;
      data_d[gpio_bank_pkg::FAN_SHARED_PORT] = 1'b0;
      cfg_d[gpio_bank_pkg::SERIAL_TX_SHARED_PORT] = gpio_bank_pkg::CFG_RESET_OUTPUT;
      data_d[gpio_bank_pkg::SERIAL_TX_SHARED_PORT] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // event status next value
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] clr;
    logic [8:0] widx;
    widx = word_idx(awaddr_i);
    clr = 32'h0;
    if (wr_en && !widx[8] && widx[7:0] == gpio_bank_pkg::EVT_STATUS_IDX) begin
      clr = wdata_i & {{8{wstrb_i[3]}}, {8{wstrb_i[2]}}, {8{wstrb_i[1]}}, {8{wstrb_i[0]}}};
    end
    // a new event wins over a clear in the same cycle
    status_d = (status_q & ~clr) | (pin_edge & (wake_en | smi_en));
  end

  // ----------------------------------------------------------------
  // register file flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NP; i++) begin
        cfg_q[i] <= gpio_bank_pkg::CFG_RESET_INPUT;
      end
      cfg_q[gpio_bank_pkg::SERIAL_TX_SHARED_PORT] <= gpio_bank_pkg::CFG_RESET_OUTPUT;
      data_q <= '0;
      status_q <= 32'h0;
      mask_q <= gpio_bank_pkg::EVT_MASK_RESET;
      bresp_q <= gpio_bank_pkg::RESP_OKAY;
    end else begin
      cfg_q <= cfg_d;
      data_q <= data_d;
      status_q <= status_d;
      mask_q <= mask_d;
      bresp_q <= bresp_d;
    end
  end

  // ----------------------------------------------------------------
  // read path: snapshot taken at the read handshake
  // ----------------------------------------------------------------
  always_comb begin
    logic [8:0] ridx;
    logic [2:0] rbank;
    ridx = word_idx(araddr_i);
    rbank = data_bank(ridx[7:0]);
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rd_en) begin
      rdata_d = 32'h0;
      rresp_d = gpio_bank_pkg::RESP_OKAY;
      if (ridx[8]) begin
        rresp_d = gpio_bank_pkg::RESP_SLVERR;
      end else if (rbank[2]) begin
        // input ports show the pin, outputs the written bit
        for (int j = 0; j < 8; j++) begin
          rdata_d[j] = is_input[rbank[1:0]*8 + j] ? pin_lvl[rbank[1:0]*8 + j]
                                                  : data_q[rbank[1:0]*8 + j];
        end
      end else if (ridx[7:5] == gpio_bank_pkg::CFG_BASE_TOP) begin
        rdata_d[gpio_bank_pkg::CFG_W-1:0] = cfg_q[ridx[4:0]];
      end else if (ridx[7:0] == gpio_bank_pkg::EVT_STATUS_IDX) begin
        rdata_d = status_q;
      end else if (ridx[7:0] == gpio_bank_pkg::EVT_MASK_IDX) begin
        rdata_d = mask_q;
      end else begin
        rresp_d = gpio_bank_pkg::RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus handshake next values
  // ----------------------------------------------------------------
  always_comb begin
    // take address and data together, one write in flight
    awready_d = awvalid_i && wvalid_i && !bvalid_q && !awready_q;
    bvalid_d = bvalid_q;
    if (wr_en) begin
      bvalid_d = 1'b1;
    end else if (bvalid_q && bready_i) begin
      bvalid_d = 1'b0;
    end
    // one read in flight
    arready_d = arvalid_i && !rvalid_q && !arready_q;
    rvalid_d = rvalid_q;
    if (rd_en) begin
      rvalid_d = 1'b1;
    end else if (rvalid_q && rready_i) begin
      rvalid_d = 1'b0;
    end
  end

  // bus handshake flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      awready_q <= 1'b0;
      bvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= gpio_bank_pkg::RESP_OKAY;
      rdata_q <= 32'h0;
    end else begin
      awready_q <= awready_d;
      bvalid_q <= bvalid_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  logic [NP-1:0] pin_out_q;
  logic [NP-1:0] pin_out_d;
  logic [NP-1:0] pin_oe_q;
  logic [NP-1:0] pin_oe_d;

  // alternate function owns the pin, else data bit when output
  genvar gd;
  generate
    for (gd = 0; gd < NP; gd++) begin : g_drive
      always_comb begin
        pin_out_d[gd] = is_alt[gd] ? alt_out_i[gd] : data_q[gd];
        pin_oe_d[gd] = is_alt[gd] ? alt_oe_i[gd] : !is_input[gd];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // event outputs
  // ----------------------------------------------------------------
  logic wake_n_q;
  logic wake_n_d;
  logic smi_n_q;
  logic smi_n_d;
  logic irq_q;
  logic irq_d;

  // outputs follow flags only while enabled
  always_comb begin
    wake_n_d = !(|(status_q & wake_en));
    smi_n_d = !(|(status_q & smi_en));
    irq_d = |(status_q & mask_q);
  end

  // pin and event flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
      wake_n_q <= 1'b1;
      smi_n_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
      wake_n_q <= wake_n_d;
      smi_n_q <= smi_n_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready_o = awready_q;
  assign wready_o = awready_q;
  assign bvalid_o = bvalid_q;
  assign bresp_o = bresp_q;
  assign arready_o = arready_q;
  assign rvalid_o = rvalid_q;
  assign rresp_o = rresp_q;
  assign rdata_o = rdata_q;
  assign gpio_out_o = pin_out_q;
  assign gpio_oe_o = pin_oe_q;
  assign wake_event_pin_n_o = wake_n_q;
  assign mgmt_interrupt_pin_n_o = smi_n_q;
  assign irq_o = irq_q;

endmodule : general_purpose_io_bank
`default_nettype wire

// ### tb/gpio_bank_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// port-level properties of the gpio bank
// ------------------------------------------------------------
module gpio_bank_properties (
  // clock and resets
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic main_por_i,
  // register bus
  input wire logic [gpio_bank_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  input wire logic wvalid_i,
  input wire logic awready_o,
  input wire logic wready_o,
  input wire logic [1:0] bresp_o,
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic [gpio_bank_pkg::ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0] rresp_o,
  input wire logic rvalid_o,
  input wire logic rready_i,
  // pins and events
  input wire logic [gpio_bank_pkg::NUM_PORTS-1:0] gpio_out_o,
  input wire logic [gpio_bank_pkg::NUM_PORTS-1:0] gpio_oe_o,
  input wire logic wake_event_pin_n_o,
  input wire logic irq_o
);
  localparam int TX = gpio_bank_pkg::SERIAL_TX_SHARED_PORT; // serial tx shared port
  localparam int FAN = gpio_bank_pkg::FAN_SHARED_PORT; // fan shared port
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_write_answer: assert property (awvalid_i && wvalid_i && awready_o |=> bvalid_o)
    else $error("write handshake without response");
  a_ready_pair: assert property (awready_o |-> wready_o && awvalid_i && wvalid_i && !bvalid_o)
    else $error("write readies out of step");
  a_write_hold: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write response dropped early");
  a_write_misalign: assert property (awvalid_i && awready_o && awaddr_i[1:0] != 2'h0 |=>
    bresp_o == gpio_bank_pkg::RESP_SLVERR) else $error("misaligned write accepted");
  a_read_answer: assert property (arvalid_i && arready_o |=> rvalid_o)
    else $error("read handshake without data");
  a_read_misalign: assert property (arvalid_i && arready_o && araddr_i[1:0] != 2'h0 |=>
    rresp_o == gpio_bank_pkg::RESP_SLVERR && rdata_o == 32'h0) else $error("misaligned read accepted");
  a_read_latched: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o) && $stable(rresp_o))
    else $error("read data not held");
  a_arready_pulse: assert property (arready_o |=> !arready_o)
    else $error("read ready longer than one cycle");
  a_reset_defaults: assert property ($rose(rst_n_i) |-> ##2 gpio_oe_o[TX] && !gpio_out_o[TX] && !gpio_oe_o[FAN])
    else $error("pin defaults wrong after reset");
  a_main_por_force: assert property (main_por_i [*8] |-> gpio_oe_o[FAN] && !gpio_out_o[FAN] && gpio_oe_o[TX])
    else $error("main reset did not force shared ports low");

  // main scenarios reached
  c_irq: cover property (irq_o);
  c_wake: cover property (!wake_event_pin_n_o);
  c_error: cover property (bvalid_o && bresp_o == gpio_bank_pkg::RESP_SLVERR);
endmodule : gpio_bank_properties
`default_nettype wire

// ### tb/gpio_board_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// board side of the pins
// ------------------------------------------------------------
module gpio_board_model (
  // device drive
  input wire logic [31:0] out_i,
  input wire logic [31:0] oe_i,
  // board drivers
  input wire logic [31:0] board_i,
  // resolved pin level
  output logic [31:0] level_o
);
  // device wins where it drives, board level elsewhere
  assign level_o = (oe_i & out_i) | (~oe_i & board_i);
endmodule : gpio_board_model
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// bench: bus master, board drive, result monitor
// ------------------------------------------------------------
module testbench;
  localparam logic [1:0] OK = gpio_bank_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = gpio_bank_pkg::RESP_SLVERR;
  localparam logic [31:0] TXM = 32'h1 << gpio_bank_pkg::SERIAL_TX_SHARED_PORT;
  localparam logic [31:0] FANM = 32'h1 << gpio_bank_pkg::FAN_SHARED_PORT;
  localparam logic [11:0] ST = {2'h0, gpio_bank_pkg::EVT_STATUS_IDX, 2'h0};
  localparam logic [11:0] MK = {2'h0, gpio_bank_pkg::EVT_MASK_IDX, 2'h0};
  localparam logic [11:0] B1 = {2'h0, gpio_bank_pkg::DATA_BANK_ONE_IDX, 2'h0};
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic main_por_i = 1'h0;
  logic [11:0] awaddr_i = 12'h0;
  logic [11:0] araddr_i = 12'h0;
  logic [31:0] wdata_i = 32'h0;
  logic [3:0] wstrb_i = 4'hF;
  logic awvalid_i = 1'h0;
  logic wvalid_i = 1'h0;
  logic bready_i = 1'h0;
  logic arvalid_i = 1'h0;
  logic rready_i = 1'h0;
  logic [31:0] board_q = 32'h0;
  logic [31:0] alt_out_i = 32'h0;
  logic [31:0] alt_oe_i = 32'h0;
  logic [31:0] pin_w, rdata_o, gpio_out_o, gpio_oe_o, v, e;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, wake_event_pin_n_o, mgmt_interrupt_pin_n_o, irq_o;
  logic [1:0] bresp_o, rresp_o;
  logic [33:0] exp_r[$]; // expected read answers
  logic [1:0] exp_b[$]; // expected write responses
  logic [7:0] bank_idx [4] = '{gpio_bank_pkg::DATA_BANK_ONE_IDX, gpio_bank_pkg::DATA_BANK_TWO_IDX,
    gpio_bank_pkg::DATA_BANK_THREE_IDX, gpio_bank_pkg::DATA_BANK_FIVE_IDX};
  logic [15:0] rnd = 16'h0006;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;

  general_purpose_io_bank dut_u (.clk_i, .rst_n_i, .main_por_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i,
    .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o,
    .rresp_o, .rvalid_o, .rready_i, .gpio_in_i(pin_w), .gpio_out_o, .gpio_oe_o, .alt_out_i, .alt_oe_i,
    .wake_event_pin_n_o, .mgmt_interrupt_pin_n_o, .irq_o);
  gpio_board_model board_u (.out_i(gpio_out_o), .oe_i(gpio_oe_o), .board_i(board_q), .level_o(pin_w));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [11:0] ca(input int p);
    return {2'h0, gpio_bank_pkg::CFG_BASE_TOP, 5'(p), 2'h0};
  endfunction : ca

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    rnd = lfsr(rnd);
    @(posedge clk_i);
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'h1;
    wvalid_i <= 1'h1;
    do @(posedge clk_i); while (!awready_o);
    awvalid_i <= 1'h0;
    wvalid_i <= 1'h0;
    bready_i <= rnd[0];
    @(posedge clk_i);
    while (!(bvalid_o && bready_i)) begin
      bready_i <= 1'h1;
      @(posedge clk_i);
    end
    bready_i <= 1'h0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_r.push_back({r, d});
    rnd = lfsr(rnd);
    @(posedge clk_i);
    araddr_i <= a;
    arvalid_i <= 1'h1;
    do @(posedge clk_i); while (!arready_o);
    arvalid_i <= 1'h0;
    rready_i <= rnd[0];
    @(posedge clk_i);
    while (!(rvalid_o && rready_i)) begin
      rready_i <= 1'h1;
      @(posedge clk_i);
    end
    rready_i <= 1'h0;
  endtask : rd

  // pin value and enable under a mask, once settled
  task automatic pins(input logic [31:0] m, input logic [31:0] o, input logic [31:0] oe);
    repeat (4) @(posedge clk_i);
    #1;
    chk("pin_out", o & m, gpio_out_o & m);
    chk("pin_oe", oe & m, gpio_oe_o & m);
  endtask : pins

  // {irq, mgmt interrupt pin, wake pin}
  task automatic flags(input logic [2:0] f);
    repeat (8) @(posedge clk_i);
    #1;
    chk("flags", {29'h0, f}, {29'h0, irq_o, mgmt_interrupt_pin_n_o, wake_event_pin_n_o});
  endtask : flags

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // monitor: oldest note against each answer
  always @(posedge clk_i) begin
    if (bvalid_o && bready_i) begin
      chk("bresp", {30'h0, exp_b.pop_front()}, {30'h0, bresp_o});
    end
    if (rvalid_o && rready_i) begin
      chk("rdata", exp_r[0][31:0], rdata_o);
      chk("rresp", {30'h0, exp_r[0][33:32]}, {30'h0, rresp_o});
      void'(exp_r.pop_front());
    end
  end

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'h1;
    rd(ca(0), 32'h1, OK);
    rd(ca(gpio_bank_pkg::SERIAL_TX_SHARED_PORT), 32'h0, OK);
    rd(ST, 32'h0, OK);
    rd(MK, 32'h0, OK);
    pins(32'hFFFF_FFFF, 32'h0, TXM);
    flags(3'h3);
    $display("test reset finished");
    @(posedge clk_i);
    rnd = lfsr(rnd);
    v = {rnd, ~rnd};
    board_q <= v;
    repeat (6) @(posedge clk_i);
    v = v & ~TXM;
    for (int b = 0; b < 4; b++) begin
      rd({2'h0, bank_idx[b], 2'h0}, {24'h0, v[8*b +: 8]}, OK);
    end
    $display("test inputs finished");
    for (int p = 0; p < 8; p++) begin
      wr(ca(p), 32'h0, OK);
    end
    v = {24'h0, rnd[7:0]};
    wr(B1, v, OK);
    pins(32'hFF, v, 32'hFF);
    rd(B1, v, OK);
    $display("test outputs finished");
    rnd = lfsr(rnd);
    v = {rnd, rnd};
    e = {~rnd, rnd};
    alt_out_i <= v;
    alt_oe_i <= e;
    wr(ca(1), 32'h2, OK);
    pins(32'h2, v, e);
    $display("test alternate finished");
    wr(ca(8), 32'h9, OK);
    wr(ca(9), 32'h5, OK);
    wr(MK, 32'h100, OK);
    board_q <= board_q ^ 32'h300;
    flags(3'h4);
    rd(ST, 32'h300, OK);
    wr(MK, 32'h0, OK);
    flags(3'h0);
    wr(MK, 32'h100, OK);
    flags(3'h4);
    wr(ST, 32'h300, OK);
    flags(3'h3);
    rd(ST, 32'h0, OK);
    $display("test events finished");
    wr(B1 + 12'h1, 32'h0, ERR);
    rd(12'h140, 32'h0, ERR);
    rd(B1 + 12'h2, 32'h0, ERR);
    wr(ca(10), 32'hF1, OK);
    rd(ca(10), 32'h1, OK);
    $display("test errors finished");
    @(posedge clk_i);
    main_por_i <= 1'h1;
    wr(ca(gpio_bank_pkg::FAN_SHARED_PORT), 32'h1, OK);
    pins(FANM | TXM, 32'h0, FANM | TXM);
    rd(ca(gpio_bank_pkg::FAN_SHARED_PORT), 32'h0, OK);
    main_por_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    wr(ca(gpio_bank_pkg::FAN_SHARED_PORT), 32'h1, OK);
    pins(FANM, 32'h0, 32'h0);
    $display("test main reset finished");
    conclude();
  end
endmodule : testbench

bind general_purpose_io_bank gpio_bank_properties props_u (.clk_i, .rst_n_i, .main_por_i, .awaddr_i, .awvalid_i,
  .wvalid_i, .awready_o, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o,
  .rresp_o, .rvalid_o, .rready_i, .gpio_out_o, .gpio_oe_o, .wake_event_pin_n_o, .irq_o);
`default_nettype wire
